// >>> verilog/ppp_consts.svh
// Constants for the host parallel port: offsets, fields, resets, timing
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
`define PPP_LOWER_BYTES    4'd8
`define PPP_UPPER_BYTES    4'd4
`define PPP_OFF_DATA       3'h0
`define PPP_OFF_STATUS     3'h1
`define PPP_OFF_CONTROL    3'h2
`define PPP_OFF_EPP_ADDR   3'h3
`define PPP_OFF_EPP_DATA0  3'h4
`define PPP_OFF_FIFO       2'h0
`define PPP_OFF_CNFGB      2'h1
`define PPP_OFF_EXT_CTRL   2'h2
`define PPP_UPPER_DIST     12'h400
`define PPP_MODE_SPP       3'h0
`define PPP_MODE_BIDIR     3'h1
`define PPP_MODE_ECP       3'h3
`define PPP_MODE_EPP       3'h4
`define PPP_MODE_CFG       3'h7
`define PPP_CTRL_IRQ_EN    4
`define PPP_CTRL_DIR       5
`define PPP_STAT_INT       2
`define PPP_STAT_TMO       0
`define PPP_CTRL_RESET     8'h00
`define PPP_EXT_RESET      8'h01
`define PPP_CNFGA_VALUE    8'h90
`define PPP_CLK_MHZ        250
`define PPP_EPP_TMO_US     10
`define PPP_EPP_TMO_CYC    (`PPP_EPP_TMO_US * `PPP_CLK_MHZ)
`define PPP_FIFO_DEPTH     16
`define PPP_FIFO_THRESH    8
`endif

// >>> verilog/ppp_pkg.sv
// Types shared by the host parallel port
package ppp_pkg;
  typedef struct packed {
    logic       wr;   // Write strobe, one cycle
    logic       rd;   // Read strobe, one cycle
    logic       upper; // 1 selects upper block
    logic [2:0] addr; // Byte offset within block
    logic [7:0] wdata;
  } ppp_req_t;
  typedef struct packed {
    logic       ack;  // Access finished, one cycle
    logic [7:0] rdata;
  } ppp_rsp_t;
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic pe;
    logic slct;
    logic err_n;
  } ppp_stat_t;
  typedef enum logic [1:0] {
    PPP_IDLE  = 2'b00,
    PPP_STRB  = 2'b01,
    PPP_DONE  = 2'b10
  } ppp_epp_state_t;
endpackage

// >>> verilog/ppp_port.sv
// Host IEEE 1284 parallel port: SPP, bidirectional, EPP and ECP receive path
`timescale 1ns/1ps
`default_nettype none
`include "ppp_consts.svh"
module ppp_port import ppp_pkg::*; (
  input  wire logic      clk,             // 250 MHz system clock
  input  wire logic      rst_b,           // Asynchronous reset, active low
  input  wire ppp_req_t  req,             // Register access request
  output ppp_rsp_t       rsp,             // Register access answer
  output logic           irq_reg,         // Port interrupt, active high level
  input  wire logic [7:0] port_data_lines_in, // Data pin levels
  output logic [7:0]     port_data_lines_out, // Data pin drive
  output logic           port_data_lines_oe,  // High while driving data pins
  input  wire ppp_stat_t stat_in,         // Peripheral status pins
  output logic           data_strobe_out_n,   // Strobe / EPP write
  output logic           data_strobe_oe,      // Strobe drive enable
  output logic           autofeed_out_n,      // Autofeed / EPP data strobe
  output logic           autofeed_oe,         // Autofeed drive enable
  output logic           init_out_n,          // Init
  output logic           init_oe,             // Init drive enable
  output logic           select_in_out_n,     // Select-in / EPP address strobe
  output logic           select_in_oe,        // Select-in drive enable
  output logic [7:0]     rx_fifo_data,        // Receive FIFO head byte
  output logic           rx_fifo_valid,       // Receive FIFO not empty
  input  wire logic      rx_fifo_pop,         // Consumer takes head byte
  input  wire logic [7:0] ecp_rx_byte,        // Byte from ECP receive engine
  input  wire logic      ecp_rx_is_cmd,       // Byte is a run-length count
  input  wire logic      ecp_rx_valid,        // Byte strobe from ECP engine
  output logic           ecp_rx_ready         // High when a byte may be offered
);
  // Register state
  logic [7:0] port_data_reg, port_data_next;
  logic [7:0] port_control_reg, port_control_next;
  logic [7:0] extended_control_reg, extended_control_next;
  logic       int_pend_reg, int_pend_next;
  logic       tmo_reg, tmo_next;
  logic       ack_last_reg, ack_last_next;
  logic       wait_last_reg, wait_last_next;
  ppp_rsp_t   rsp_next;
  // EPP engine state
  ppp_epp_state_t epp_st_reg, epp_st_next;
  logic [11:0] epp_cnt_reg, epp_cnt_next;
  logic        epp_wr_reg, epp_wr_next;
  logic        epp_addr_reg, epp_addr_next;
  logic [7:0]  epp_byte_reg, epp_byte_next;
  // ECP receive FIFO with run-length expansion
  logic [7:0] fifo_mem [0:`PPP_FIFO_DEPTH-1];
  logic [3:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [4:0] fill_reg, fill_next;
  logic [7:0] rle_cnt_reg, rle_cnt_next;
  logic [7:0] rle_byte_reg, rle_byte_next;
  logic       rle_busy_reg, rle_busy_next;
  logic       push, pop;
  logic [2:0] mode;
  logic       epp_mode, wait_rise, ack_rise;
  logic [7:0] status_val;

  assign mode     = extended_control_reg[7:5];
  assign epp_mode = (mode == `PPP_MODE_EPP);
  // Wait sits on the busy pin in EPP mode
  assign wait_rise = stat_in.busy & ~wait_last_reg;
  // Acknowledge doubles as peripheral interrupt in EPP mode
  assign ack_rise  = stat_in.ack_n & ~ack_last_reg;
  // Bit 2 is active low, bit 1 always one, bit 0 timeout only in EPP
  assign status_val = {~stat_in.busy, stat_in.ack_n, stat_in.pe, stat_in.slct,
                       stat_in.err_n, ~int_pend_reg, 1'b1, epp_mode ? tmo_reg : 1'b1};

  // Decode of lower-block EPP register offsets, used by read and write
  function automatic logic is_epp_off(input logic [2:0] a);
    is_epp_off = (a >= `PPP_OFF_EPP_ADDR);
  endfunction

  // Register file and read path; lower block 8 bytes, upper 4 bytes
  always_comb begin
    port_data_next        = port_data_reg;
    port_control_next     = port_control_reg;
    extended_control_next = extended_control_reg;
    int_pend_next         = int_pend_reg;
    tmo_next              = tmo_reg;
    rsp_next              = '0;
    ack_last_next         = stat_in.ack_n;
    wait_last_next        = stat_in.busy;
    if (req.wr && !req.upper) begin
      if (req.addr == `PPP_OFF_DATA) begin
        port_data_next = req.wdata;
      end else if (req.addr == `PPP_OFF_CONTROL) begin
        port_control_next = {2'b00, req.wdata[5:0]};
      end
    end
    if (req.wr && req.upper && req.addr[1:0] == `PPP_OFF_EXT_CTRL) begin
      // Low bits are fixed at 00001 whatever is written; mode selects
      extended_control_next = {req.wdata[7:5], 5'b00001};
    end
    // Reads that do not start an EPP cycle answer at once
    if (req.rd && (req.upper || !(epp_mode && is_epp_off(req.addr)))) begin
      rsp_next.ack = 1'b1;
      if (!req.upper) begin
        case (req.addr)
          `PPP_OFF_DATA:    rsp_next.rdata = port_data_lines_in;
          `PPP_OFF_STATUS:  rsp_next.rdata = status_val;
          `PPP_OFF_CONTROL: rsp_next.rdata = {2'b00, port_control_reg[5:4],
                                              ~select_in_out_n, init_out_n,
                                              ~autofeed_out_n, ~data_strobe_out_n};
          default:          rsp_next.rdata = 8'h00;
        endcase
      end else begin
        case (req.addr[1:0])
          `PPP_OFF_FIFO:     rsp_next.rdata = (mode == `PPP_MODE_CFG) ?
                                              `PPP_CNFGA_VALUE : 8'h00;
          `PPP_OFF_CNFGB:    rsp_next.rdata = {1'b0, irq_reg, 6'h00};
          `PPP_OFF_EXT_CTRL: rsp_next.rdata = {mode, 2'b00,
                                               fill_reg >= `PPP_FIFO_THRESH,
                                               fill_reg == `PPP_FIFO_DEPTH,
                                               fill_reg == 5'h00};
          default:           rsp_next.rdata = 8'h00;
        endcase
      end
      if (!req.upper && req.addr == `PPP_OFF_STATUS) begin
        int_pend_next = 1'b0;
        if (epp_mode) begin
          tmo_next = 1'b0;
        end
      end
    end
    if (req.wr) begin
      rsp_next.ack = !(epp_mode && !req.upper && is_epp_off(req.addr));
    end
    // Sets follow clears so a same-cycle event is kept
    if (ack_rise && port_control_reg[`PPP_CTRL_IRQ_EN]) begin
      int_pend_next = 1'b1;
    end
    if (epp_mode && !wait_rise && epp_st_reg == PPP_STRB && epp_cnt_reg == 12'd0) begin
      tmo_next = 1'b1;
    end
    if (epp_st_reg == PPP_DONE) begin
      rsp_next.ack   = 1'b1;
      rsp_next.rdata = epp_byte_reg;
    end
  end

  // EPP cycle engine; timer only runs in EPP mode
  always_comb begin
    epp_st_next   = epp_st_reg;
    epp_cnt_next  = epp_cnt_reg;
    epp_wr_next   = epp_wr_reg;
    epp_addr_next = epp_addr_reg;
    epp_byte_next = epp_byte_reg;
    case (epp_st_reg)
      PPP_IDLE: begin
        if (epp_mode && !req.upper && is_epp_off(req.addr) && (req.wr || req.rd)) begin
          epp_st_next   = PPP_STRB;
          epp_wr_next   = req.wr;
          epp_addr_next = (req.addr == `PPP_OFF_EPP_ADDR);
          epp_byte_next = req.wdata;
          epp_cnt_next  = 12'(`PPP_EPP_TMO_CYC - 1);
        end
      end
      PPP_STRB: begin
        if (!epp_mode) begin
          epp_st_next = PPP_IDLE;
        end else if (wait_rise) begin
          if (!epp_wr_reg) begin
            epp_byte_next = port_data_lines_in;
          end
          epp_st_next = PPP_DONE;
        end else if (epp_cnt_reg == 12'd0) begin
          epp_byte_next = 8'hff; // Aborted read returns all ones
          epp_st_next   = PPP_DONE;
        end else begin
          epp_cnt_next = epp_cnt_reg - 12'd1;
        end
      end
      PPP_DONE: epp_st_next = PPP_IDLE;
      default:  epp_st_next = PPP_IDLE;
    endcase
  end

  // ECP receive: a count byte repeats the next data byte count+1 times
  always_comb begin
    rle_cnt_next  = rle_cnt_reg;
    rle_byte_next = rle_byte_reg;
    rle_busy_next = rle_busy_reg;
    push          = 1'b0;
    if (rle_busy_reg) begin
      push = (fill_reg != `PPP_FIFO_DEPTH);
      if (push) begin
        rle_cnt_next  = (rle_cnt_reg != 8'd0) ? rle_cnt_reg - 8'd1 : 8'd0;
        rle_busy_next = (rle_cnt_reg != 8'd0);
      end
    end else if (ecp_rx_valid && ecp_rx_ready) begin
      if (ecp_rx_is_cmd) begin
        rle_cnt_next = {1'b0, ecp_rx_byte[6:0]};
      end else begin
        rle_byte_next = ecp_rx_byte;
        rle_busy_next = 1'b1; // Count zero still writes once
      end
    end
    pop         = rx_fifo_pop && (fill_reg != 5'h00);
    wr_ptr_next = wr_ptr_reg + {3'b000, push};
    rd_ptr_next = rd_ptr_reg + {3'b000, pop};
    fill_next   = fill_reg + {4'h0, push} - {4'h0, pop};
  end

  // Port pin drive; control pins push-pull in EPP, open-drain style otherwise
  logic [7:0] pd_out_next;
  logic       pd_oe_next, strb_next, afd_next, init_next, select_in_out_n_next;
  logic       strb_oe_next, afd_oe_next, init_oe_next, select_in_out_n_oe_next;
  logic       cycle_act;
  always_comb begin
    cycle_act   = epp_mode && (epp_st_reg == PPP_STRB);
    pd_out_next = cycle_act ? epp_byte_reg : port_data_next;
    // Compatibility mode always drives; an EPP cycle drives only for writes; others follow direction bit
    if (cycle_act) begin
      pd_oe_next = epp_wr_reg;
    end else if (mode == `PPP_MODE_SPP) begin
      pd_oe_next = 1'b1;
    end else begin
      pd_oe_next = ~port_control_next[`PPP_CTRL_DIR];
    end
    // EPP cycle forces write, data and address strobes
    strb_next = ~(port_control_next[0] | (cycle_act & epp_wr_reg));
    afd_next  = ~(port_control_next[1] | (cycle_act & ~epp_addr_reg));
    init_next = port_control_next[2];
    select_in_out_n_next = ~(port_control_next[3] | (cycle_act & epp_addr_reg));
    strb_oe_next = epp_mode | ~strb_next;
    afd_oe_next  = epp_mode | ~afd_next;
    init_oe_next = epp_mode | ~init_next;
    select_in_out_n_oe_next = epp_mode | ~select_in_out_n_next;
  end

  // Registers; reset puts the port in compatibility mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_data_reg        <= 8'h00;
      port_control_reg     <= `PPP_CTRL_RESET;
      extended_control_reg <= `PPP_EXT_RESET;
      int_pend_reg  <= 1'b0;
      tmo_reg       <= 1'b0;
      ack_last_reg  <= 1'b1;
      wait_last_reg <= 1'b1;
      rsp           <= '0;
      epp_st_reg    <= PPP_IDLE;
      epp_cnt_reg   <= 12'd0;
      epp_wr_reg    <= 1'b0;
      epp_addr_reg  <= 1'b0;
      epp_byte_reg  <= 8'h00;
      wr_ptr_reg    <= 4'h0;
      rd_ptr_reg    <= 4'h0;
      fill_reg      <= 5'h00;
      rle_cnt_reg   <= 8'h00;
      rle_byte_reg  <= 8'h00;
      rle_busy_reg  <= 1'b0;
      irq_reg       <= 1'b0;
      port_data_lines_out <= 8'h00;
      port_data_lines_oe  <= 1'b1;
      data_strobe_out_n <= 1'b1;
      autofeed_out_n    <= 1'b1;
      init_out_n        <= 1'b1;
      select_in_out_n   <= 1'b1;
      data_strobe_oe    <= 1'b0;
      autofeed_oe       <= 1'b0;
      init_oe           <= 1'b0;
      select_in_oe      <= 1'b0;
      rx_fifo_data      <= 8'h00;
      rx_fifo_valid     <= 1'b0;
      ecp_rx_ready      <= 1'b0;
    end else begin
      port_data_reg        <= port_data_next;
      port_control_reg     <= port_control_next;
      extended_control_reg <= extended_control_next;
      int_pend_reg  <= int_pend_next;
      tmo_reg       <= tmo_next;
      ack_last_reg  <= ack_last_next;
      wait_last_reg <= wait_last_next;
      rsp           <= rsp_next;
      epp_st_reg    <= epp_st_next;
      epp_cnt_reg   <= epp_cnt_next;
      epp_wr_reg    <= epp_wr_next;
      epp_addr_reg  <= epp_addr_next;
      epp_byte_reg  <= epp_byte_next;
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      fill_reg      <= fill_next;
      rle_cnt_reg   <= rle_cnt_next;
      rle_byte_reg  <= rle_byte_next;
      rle_busy_reg  <= rle_busy_next;
      // Interrupt gated by enable bit
      irq_reg <= int_pend_next & port_control_next[`PPP_CTRL_IRQ_EN];
      port_data_lines_out <= pd_out_next;
      port_data_lines_oe  <= pd_oe_next;
      data_strobe_out_n <= strb_next;
      autofeed_out_n    <= afd_next;
      init_out_n        <= init_next;
      select_in_out_n   <= select_in_out_n_next;
      data_strobe_oe    <= strb_oe_next;
      autofeed_oe       <= afd_oe_next;
      init_oe           <= init_oe_next;
      select_in_oe      <= select_in_out_n_oe_next;
      rx_fifo_data      <= (push && rd_ptr_next == wr_ptr_reg) ? rle_byte_reg
                                                               : fifo_mem[rd_ptr_next];
      rx_fifo_valid     <= (fill_next != 5'h00);
      // Only offer intake in ECP mode while no expansion is running
      ecp_rx_ready <= (mode == `PPP_MODE_ECP) & ~rle_busy_next;
    end
  end

  // FIFO storage has no reset; contents are qualified by the fill count
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= rle_byte_reg;
    end
  end
endmodule
`default_nettype wire

// >>> bench/ppp_port_asserts.sv
// Concurrent checks on the host parallel port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "ppp_consts.svh"
module ppp_port_asserts import ppp_pkg::*; (
  input wire logic       clk,                 // System clock
  input wire logic       rst_b,               // Reset, active low
  input wire ppp_req_t   req,                 // Register request
  input wire ppp_rsp_t   rsp,                 // Register answer
  input wire logic       irq_reg,             // Port interrupt
  input wire ppp_stat_t  stat_in,             // Status pins
  input wire logic [7:0] port_data_lines_out, // Data drive
  input wire logic       port_data_lines_oe,  // Data enable
  input wire logic       data_strobe_oe,      // Strobe enable
  input wire logic       autofeed_oe,         // Autofeed enable
  input wire logic       init_oe,             // Init enable
  input wire logic       select_in_oe,        // Select-in enable
  input wire logic       ecp_rx_ready         // ECP byte ready
);
  logic [2:0] mode_reg, mode_next;
  logic       en_reg, en_next, acc, epp_sel;
  logic       epp_open_reg;
  logic [11:0] epp_age_reg;
  // Shadow mode and interrupt enable; checks wait a cycle after a change
  always_comb begin
    mode_next = (req.wr && req.upper && req.addr == 3'h2) ? req.wdata[7:5] : mode_reg;
    en_next = (req.wr && !req.upper && req.addr == `PPP_OFF_CONTROL) ? req.wdata[4] : en_reg;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `PPP_MODE_SPP;
      en_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      en_reg <= en_next;
    end
  end
  // Age of an open port cycle; a dead peripheral must still see the cycle end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      epp_open_reg <= 1'b0;
      epp_age_reg  <= 12'd0;
    end else if (acc && epp_sel) begin
      epp_open_reg <= 1'b1;
      epp_age_reg  <= 12'd0;
    end else if (rsp.ack) begin
      epp_open_reg <= 1'b0;
    end else if (epp_open_reg) begin
      epp_age_reg <= epp_age_reg + 12'd1;
    end
  end
  assign acc = req.wr || req.rd;
  assign epp_sel = !req.upper && req.addr >= `PPP_OFF_EPP_ADDR && mode_reg == `PPP_MODE_EPP;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_one_cycle_a: assert property (rsp.ack |=> !rsp.ack)
    else $error("answer held beyond one cycle");
  plain_answer_a: assert property (acc && !epp_sel |=> rsp.ack)
    else $error("register access not answered next cycle");
  epp_bounded_a: assert property (epp_open_reg |-> epp_age_reg <= 12'd2520)
    else $error("port cycle neither finished nor aborted");
  data_follow_a: assert property (req.wr && !req.upper && req.addr == 3'h0
    && mode_reg == `PPP_MODE_SPP |=> port_data_lines_out == $past(req.wdata))
    else $error("data lines miss the written byte");
  spp_drive_a: assert property (mode_reg == 3'h0 && $past(mode_reg) == 3'h0
    |-> port_data_lines_oe)
    else $error("data lines released in compatibility mode");
  epp_pushpull_a: assert property (mode_reg == 3'h4 && $past(mode_reg) == 3'h4
    |-> data_strobe_oe && autofeed_oe && init_oe && select_in_oe)
    else $error("control pin not push-pull in EPP mode");
  irq_gated_a: assert property (!en_reg && !$past(en_reg) |-> !irq_reg)
    else $error("interrupt while disabled");
  irq_raise_a: assert property (en_reg && $rose(stat_in.ack_n) |-> ##[1:4] irq_reg)
    else $error("acknowledge edge raised no interrupt");
  irq_clear_a: assert property (req.rd && !req.upper && req.addr == `PPP_OFF_STATUS
    && stat_in.ack_n && !$rose(stat_in.ack_n) |-> ##[1:2] !irq_reg)
    else $error("status read left interrupt set");
  ecp_idle_a: assert property (mode_reg != 3'h3 && $past(mode_reg) != 3'h3
    |-> !ecp_rx_ready)
    else $error("ECP input ready outside ECP mode");
  cover property (acc && epp_sel ##[2:30] rsp.ack);
  cover property (irq_reg);
  cover property (ecp_rx_ready);
endmodule
bind ppp_port ppp_port_asserts ppp_port_asserts_inst (.clk(clk), .rst_b(rst_b),
  .req(req), .rsp(rsp), .irq_reg(irq_reg), .stat_in(stat_in),
  .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
  .data_strobe_oe(data_strobe_oe), .autofeed_oe(autofeed_oe), .init_oe(init_oe),
  .select_in_oe(select_in_oe), .ecp_rx_ready(ecp_rx_ready));
`default_nettype wire

// >>> bench/ppp_periph_model.sv
// Behavioural peripheral on the far side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module ppp_periph_model import ppp_pkg::*; (
  input  wire logic       clk,      // System clock
  input  wire logic       rst_b,    // Reset, active low
  input  wire logic       astb_n,   // Host address strobe
  input  wire logic       dstb_n,   // Host data strobe
  input  wire logic       write_n,  // Host direction, low writes
  input  wire logic       mute,     // High: never answer
  input  wire logic       kick,     // Request one acknowledge pulse
  input  wire logic [7:0] rd_byte,  // Byte returned on reads
  output ppp_stat_t       stat,     // Status pins toward host
  output logic [7:0]      data,     // Data pin drive
  output logic            data_oe   // High while driving data
);
  logic [2:0] cnt;
  logic [1:0] ack_cnt;
  logic       strobe;
  assign strobe = !astb_n || !dstb_n;
  // Wait rises some cycles into a strobe and falls once the host lets go
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 3'h0;
      ack_cnt <= 2'h0;
      stat <= '{busy: 1'b0, ack_n: 1'b1, pe: 1'b0, slct: 1'b1, err_n: 1'b1};
      data <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      cnt <= (strobe && cnt != 3'h5) ? cnt + 3'h1 : (strobe ? cnt : 3'h0);
      stat.busy <= strobe && !mute && cnt == 3'h5;
      data_oe <= strobe && write_n;
      // Released lines toggle each cycle between the last byte and its complement
      data <= (strobe && write_n) ? rd_byte : ~data;
      ack_cnt <= kick ? 2'h2 : (ack_cnt != 2'h0 ? ack_cnt - 2'h1 : 2'h0);
      stat.ack_n <= ack_cnt == 2'h0 && !kick;
    end
  end
endmodule
`default_nettype wire

// >>> bench/ppp_port_tb_top.sv
// Self-checking bench for the host parallel port
`timescale 1ns/1ps
`default_nettype none
`include "ppp_consts.svh"
module ppp_port_tb_top import ppp_pkg::*;;
  localparam logic [2:0] ext = 3'h2;
  localparam logic [2:0] ctl = `PPP_OFF_CONTROL;
  localparam logic [2:0] sts = `PPP_OFF_STATUS;
  localparam logic [2:0] epd = `PPP_OFF_EPP_DATA0;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  ppp_req_t   req;
  ppp_rsp_t   rsp;
  ppp_stat_t  stat;
  logic [7:0] pd_out, pd_in, per_data, fifo_data, ecp_byte, rd_byte, q, seen_data;
  logic       irq_reg, pd_oe, per_oe, strb_n, strb_oe, afd_n, afd_oe, init_n, init_oe;
  logic       select_in_out_n_n, select_in_out_n_oe, fifo_valid, fifo_pop, ecp_cmd, ecp_valid, ecp_ready;
  logic       mute, kick, seen_wr, seen_as;
  int         fail_count, cmp_count, got, i;
  time        t0;
  always #2 clk = ~clk;
  // Wire level seen by the host port
  assign pd_in = pd_oe ? pd_out : per_data;
  ppp_port ppp_port_inst (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .irq_reg(irq_reg),
    .port_data_lines_in(pd_in), .port_data_lines_out(pd_out), .port_data_lines_oe(pd_oe),
    .stat_in(stat), .data_strobe_out_n(strb_n), .data_strobe_oe(strb_oe),
    .autofeed_out_n(afd_n), .autofeed_oe(afd_oe), .init_out_n(init_n), .init_oe(init_oe),
    .select_in_out_n(select_in_out_n_n), .select_in_oe(select_in_out_n_oe), .rx_fifo_data(fifo_data),
    .rx_fifo_valid(fifo_valid), .rx_fifo_pop(fifo_pop), .ecp_rx_byte(ecp_byte),
    .ecp_rx_is_cmd(ecp_cmd), .ecp_rx_valid(ecp_valid), .ecp_rx_ready(ecp_ready));
  ppp_periph_model ppp_periph_model_inst (.clk(clk), .rst_b(rst_b), .astb_n(select_in_out_n_n),
    .dstb_n(afd_n), .write_n(strb_n), .mute(mute), .kick(kick), .rd_byte(rd_byte),
    .stat(stat), .data(per_data), .data_oe(per_oe));
  // Record what the pins showed while a port cycle strobe was active
  always @(posedge clk) begin
    if (!afd_n) begin
      seen_data <= pd_out;
      seen_wr <= strb_n;
    end
    if (!select_in_out_n_n) seen_as <= 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One register access: one-cycle request, then wait for the answer
  task automatic acc(input logic wr, input logic up, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    req = '{wr: wr, rd: !wr, upper: up, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    // Answer stands one cycle, so it is looked at on each falling edge
    for (n = 0; n < 3000 && rsp.ack !== 1'b1; n++) @(negedge clk);
    q = rsp.rdata;
    if (n == 3000) begin
      fail_count++;
      $display("ERROR at %0t: no answer", $time);
    end
  endtask
  task automatic rdc(input logic up, input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, up, a, 8'h00);
    check(q, exp);
  endtask
  task automatic pulse_ack();
    @(negedge clk);
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // Offer one inbound ECP byte, held until taken
  task automatic ecp_send(input logic c, input logic [7:0] b);
    int n;
    @(negedge clk);
    {ecp_cmd, ecp_byte, ecp_valid} = {c, b, 1'b1};
    for (n = 0; n < 200 && ecp_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    ecp_valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #80000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {req, fifo_pop, ecp_byte, ecp_cmd, ecp_valid, mute, kick, seen_as} = '0;
    rd_byte = 8'ha7;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rdc(1'b1, ext, 8'h01);
    acc(1'b1, 1'b0, ctl, 8'h05);
    rdc(1'b0, ctl, 8'h05);
    acc(1'b1, 1'b0, ctl, 8'h20);
    acc(1'b1, 1'b0, 3'h0, 8'h55);
    check({7'h00, pd_oe}, 8'h01);
    check(pd_out, 8'h55);
    rdc(1'b0, sts, 8'hdf);
    acc(1'b1, 1'b1, ext, 8'h21);
    acc(1'b1, 1'b0, ctl, 8'h20);
    @(negedge clk);
    check({7'h00, pd_oe}, 8'h00);
    acc(1'b1, 1'b0, ctl, 8'h00);
    @(negedge clk);
    check({7'h00, pd_oe}, 8'h01);
    acc(1'b1, 1'b1, ext, 8'h81);
    @(negedge clk);
    check({4'h0, strb_oe, afd_oe, init_oe, select_in_out_n_oe}, 8'h0f);
    acc(1'b1, 1'b0, epd, 8'h3c);
    check(seen_data, 8'h3c);
    check({7'h00, seen_wr}, 8'h00);
    acc(1'b1, 1'b0, `PPP_OFF_EPP_ADDR, 8'h5a);
    check({7'h00, seen_as}, 8'h01);
    rdc(1'b0, epd, 8'ha7);
    rdc(1'b0, sts, 8'hde);
    mute = 1'b1;
    t0 = $time;
    acc(1'b1, 1'b0, epd, 8'h11);
    check({7'h00, ($time - t0) >= 10000}, 8'h01);
    mute = 1'b0;
    rdc(1'b0, sts, 8'hdf);
    rdc(1'b0, sts, 8'hde);
    acc(1'b1, 1'b1, ext, 8'he1);
    rdc(1'b1, 3'h0, 8'h90);
    rdc(1'b1, 3'h3, 8'h00);
    acc(1'b1, 1'b1, ext, 8'h01);
    pulse_ack();
    check({7'h00, irq_reg}, 8'h00);
    rdc(1'b0, sts, 8'hdf);
    acc(1'b1, 1'b0, ctl, 8'h10);
    pulse_ack();
    check({7'h00, irq_reg}, 8'h01);
    rdc(1'b0, sts, 8'hdb);
    @(negedge clk);
    check({7'h00, irq_reg}, 8'h00);
    rdc(1'b0, sts, 8'hdf);
    acc(1'b1, 1'b1, ext, 8'h61);
    ecp_send(1'b1, 8'h03);
    ecp_send(1'b0, 8'haa);
    repeat (10) @(negedge clk);
    rdc(1'b1, ext, 8'h60);
    got = 0;
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      fifo_pop = fifo_valid;
      if (fifo_valid === 1'b1) got++;
      if (fifo_valid === 1'b1) check(fifo_data, 8'haa);
    end
    fifo_pop = 1'b0;
    check(got[7:0], 8'h04);
    rdc(1'b1, ext, 8'h61);
    tally_and_finish();
  end
endmodule
`default_nettype wire
